// file: include/dba_pkg.sv
// Shared constants and carriers for the data memory bank addressing block.
// Assumes a single clock domain shared with the CPU core.
package dba_pkg;

  // ***************************************************************
  // Address and field layout
  // ***************************************************************
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int WBS_W = 4;
  localparam int SEL_PAIR_W = 8;
  // Position of the fields inside the bank select pair
  localparam int WBS_LSB = 4;
  localparam int MBS_LSB = 0;
  // Vector entry bit positions for the enable flags
  localparam int VEC_WIDE_BIT = 7;
  localparam int VEC_REGX_BIT = 6;
  localparam int VEC_W = 8;
  // Reset values and the fixed low and high bank numbers
  localparam logic [3:0] MBS_RESET = 4'h0;
  localparam logic [3:0] WBS_RESET = 4'h0;
  localparam logic [3:0] BANK_HIGH = 4'hf;
  localparam logic [3:0] BANK_LOW = 4'h0;
  // Short direct area pages in bank 15
  localparam logic [3:0] SHORT_PAGE_LO = 4'hb;
  localparam logic [3:0] SHORT_PAGE_HI = 4'hf;
  // Low index bit area base page
  localparam logic [1:0] LIDX_TOP = 2'h3;
  // Highest working register bank number
  localparam logic [3:0] WBS_MAX = 4'h3;

  // ***************************************************************
  // Access kinds
  // ***************************************************************
  typedef enum logic [2:0] {
    DBA_DIRECT,
    DBA_IND_HL,
    DBA_IND_IDX,
    DBA_BIT_SHORT,
    DBA_BIT_LIDX,
    DBA_BIT_HIDX
  } dba_mode_e;

  // Access request from the decoder
  typedef struct packed {
    dba_mode_e mode;
    logic [7:0] operand;
    logic [7:0] index;
    logic [1:0] bit_in;
  } dba_req_s;

  // Effective address answer
  typedef struct packed {
    logic [11:0] addr;
    logic [1:0] bit_sel;
  } dba_addr_s;

endpackage : dba_pkg

// file: hw/dba_addr_gen.sv
// Combinational effective address former.
// Assumes flags and selects come from registers on the same clock.
module dba_addr_gen (
  input wire dba_pkg::dba_req_s req,
  input wire logic wide_ram_enable,
  input wire logic [3:0] memory_bank_select,
  output dba_pkg::dba_addr_s ea
);

  // ***************************************************************
  // Bank choice per mode
  // ***************************************************************
  // Narrow direct: low half goes to bank 0, high half to bank 15
  wire logic [3:0] narrow_dir_bank = req.operand[7] ? dba_pkg::BANK_HIGH : dba_pkg::BANK_LOW;
  wire logic [3:0] dir_bank = wide_ram_enable ? memory_bank_select : narrow_dir_bank; // [R1] [R2] [R3]
  wire logic [3:0] ind_bank = wide_ram_enable ? memory_bank_select : dba_pkg::BANK_LOW; // [R4] [R13]
  // High index nibble joined with the operand low nibble
  wire logic [7:0] hidx_off = {req.index[7:4], req.operand[3:0]};
  // Low index bit form: operand low nibble and index bits 3:2
  wire logic [11:0] lidx_addr = {dba_pkg::BANK_HIGH, dba_pkg::LIDX_TOP, req.operand[3:0], req.index[3:2]}; // [R12]
  // Short area: operand bit 6 picks FBx versus FFx
  wire logic [3:0] short_page = req.operand[6] ? dba_pkg::SHORT_PAGE_HI : dba_pkg::SHORT_PAGE_LO;

  // Mode mux; purely combinational so the access sees it same cycle
  always_comb begin // [R22] [R14]
    ea.bit_sel = req.bit_in;
    case (req.mode)
      dba_pkg::DBA_DIRECT: ea.addr = {dir_bank, req.operand};
      dba_pkg::DBA_IND_HL: ea.addr = {ind_bank, req.index};
      dba_pkg::DBA_IND_IDX: ea.addr = {dba_pkg::BANK_LOW, req.index}; // [R10]
      dba_pkg::DBA_BIT_SHORT: ea.addr = {dba_pkg::BANK_HIGH, short_page, req.operand[3:0]}; // [R11]
      dba_pkg::DBA_BIT_LIDX: begin
        ea.addr = lidx_addr;
        ea.bit_sel = req.index[1:0]; // [R12]
      end
      dba_pkg::DBA_BIT_HIDX: ea.addr = {ind_bank, hidx_off}; // [R13]
      default: ea.addr = {dir_bank, req.operand};
    endcase
  end

endmodule : dba_addr_gen

// file: hw/dba_bank_unit.sv
// Bank select state, enable flags and address generation for the core.
// Assumes the decoder gives one-cycle strobes and the core holds the
// program memory vector byte valid while its load strobe is high.

// How it works
// R1 - Bank select forms upper address nibble
// R2 - Wide mode: bank select picks page
// R3 - Narrow direct: bank 0 low, bank 15 high
// R4 - Narrow indirect: bank 0 page only
// R5 - Software enables wide mode for peripherals
// R6 - Reset loads wide flag from vector bit 7
// R7 - Interrupt loads wide flag from vector bit 7
// R8 - Wide flag saved and restored over interrupts
// R9 - Bit instructions set or clear both flags
// R10 - Index pair and stack reach page 0
// R11 - Short bit area always in bank 15
// R12 - Low index bit form in FC0H-FFFH
// R13 - High index bit form uses bank select
// R14 - Carry bit ops take three bit forms
// R15 - Bank select pair is eight bits
// R16 - Pair pushed and popped as one byte
// R17 - Working bank select 0-3, reset zero; a pair pop loads all four bits, up to 15
// R18 - Memory bank select 0-15, reset zero
// R19 - Software uses even address for bytes
// R20 - Register extend clear forces bank 0
// R21 - Register extend loaded from vector bit 6
// R22 - Address formed combinationally same cycle
module dba_bank_unit (
  input wire logic clock,
  input wire logic rst,
  // Vector byte load after internal reset or on interrupt entry
  input wire logic vec_load,
  input wire logic [7:0] vec_byte,
  // Interrupt entry save and return restore of the flags
  input wire logic irq_save,
  input wire logic irq_restore,
  input wire logic [1:0] stacked_flags,
  output logic [1:0] flags_to_stack,
  // Bit set and clear on the flags
  input wire logic wide_bit_we,
  input wire logic regx_bit_we,
  input wire logic bit_value,
  // Dedicated select instructions
  input wire logic wbs_load,
  input wire logic [1:0] wbs_value,
  input wire logic mbs_load,
  input wire logic [3:0] mbs_value,
  // Pair push and pop
  input wire logic pair_pop,
  input wire logic [7:0] pair_pop_data,
  output logic [7:0] bank_select_pair,
  // Access request and effective address
  input wire dba_pkg::dba_req_s req,
  output dba_pkg::dba_addr_s ea,
  // Flags and working bank in use
  output logic wide_ram_enable,
  output logic register_bank_extend,
  output logic [1:0] working_bank
);

  // ***************************************************************
  // State registers
  // ***************************************************************
  logic wide_reg;
  logic wide_next;
  logic regx_reg;
  logic regx_next;
  logic [3:0] wbs_reg;
  logic [3:0] wbs_next;
  logic [3:0] mbs_reg;
  logic [3:0] mbs_next;

  // Priority pick among the three flag sources, used twice below
  function automatic logic flag_pick(input logic cur, input logic vec_v, input logic vec_b,
                                     input logic bit_we, input logic bit_v,
                                     input logic rst_v, input logic st_b);
    logic r;
    r = cur;
    if (rst_v) begin
      r = st_b;
    end
    if (bit_we) begin
      r = bit_v;
    end
    // Vector load wins: it marks a fresh reset or interrupt entry
    if (vec_v) begin
      r = vec_b;
    end
    return r;
  endfunction : flag_pick

  // ***************************************************************
  // Next-state selection
  // ***************************************************************
  // Flag sources: vector byte, bit instructions, stack restore
  assign wide_next = flag_pick(wide_reg, vec_load, vec_byte[dba_pkg::VEC_WIDE_BIT],
                               wide_bit_we, bit_value, irq_restore, stacked_flags[1]); // [R6] [R7] [R8] [R9]
  assign regx_next = flag_pick(regx_reg, vec_load, vec_byte[dba_pkg::VEC_REGX_BIT],
                               regx_bit_we, bit_value, irq_restore, stacked_flags[0]); // [R21] [R9]
  // Select fields: pop restores both, dedicated loads change one
  assign wbs_next = pair_pop ? pair_pop_data[dba_pkg::WBS_LSB +: dba_pkg::WBS_W] :
                    wbs_load ? {2'b00, wbs_value} : wbs_reg; // [R16] [R17]
  assign mbs_next = pair_pop ? pair_pop_data[dba_pkg::MBS_LSB +: dba_pkg::BANK_W] :
                    mbs_load ? mbs_value : mbs_reg; // [R16] [R18]

  // Flags clear on reset; the boot vector byte then sets them.
  // Until it arrives they sit at zero, the narrow and safe setting.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wide_reg <= 1'b0;
      regx_reg <= 1'b0;
    end else begin
      wide_reg <= wide_next;
      regx_reg <= regx_next;
    end
  end

  // Select fields clear on reset and hold until software writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wbs_reg <= dba_pkg::WBS_RESET; // [R17]
      mbs_reg <= dba_pkg::MBS_RESET; // [R18]
    end else begin
      wbs_reg <= wbs_next;
      mbs_reg <= mbs_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign bank_select_pair = {wbs_reg, mbs_reg}; // [R15] [R16]
  assign flags_to_stack = {wide_reg, regx_reg}; // [R8]
  assign wide_ram_enable = wide_reg;
  assign register_bank_extend = regx_reg;
  // Extend clear pins the working set to bank 0
  assign working_bank = regx_reg ? wbs_reg[1:0] : 2'b00; // [R20]

  // Address former; caller keeps byte operands even by convention
  dba_addr_gen u_addr (
    .req(req),
    .wide_ram_enable(wide_reg),
    .memory_bank_select(mbs_reg),
    .ea(ea)
  );

  // ***************************************************************
  // Checks
  // ***************************************************************
  wide_vec_load_a : assert property (@(posedge clock) disable iff (rst)
    vec_load |=> wide_ram_enable == $past(vec_byte[7])) // [R6] [R7]
    else $error("wide flag not loaded from vector bit 7");
  regx_vec_load_a : assert property (@(posedge clock) disable iff (rst)
    vec_load |=> register_bank_extend == $past(vec_byte[6])) // [R21]
    else $error("extend flag not loaded from vector bit 6");
  flag_restore_a : assert property (@(posedge clock) disable iff (rst)
    (irq_restore && !vec_load && !wide_bit_we && !regx_bit_we) |=> flags_to_stack == $past(stacked_flags)) // [R8]
    else $error("flags not restored from stack");
  bit_write_a : assert property (@(posedge clock) disable iff (rst)
    (wide_bit_we && !vec_load) |=> wide_ram_enable == $past(bit_value)) // [R9]
    else $error("bit write to wide flag lost");
  pair_pop_a : assert property (@(posedge clock) disable iff (rst)
    pair_pop |=> bank_select_pair == $past(pair_pop_data)) // [R16]
    else $error("pair pop not restored as one byte");
  mbs_hold_a : assert property (@(posedge clock) disable iff (rst)
    (!pair_pop && !mbs_load) |=> $stable(bank_select_pair[3:0])) // [R18]
    else $error("memory bank select changed without write");
  wbs_range_a : assert property (@(posedge clock) disable iff (rst)
    (wbs_load && !pair_pop) |=> bank_select_pair[7:4] <= dba_pkg::WBS_MAX) // [R17]
    else $error("working bank select out of range");
  regx_bank0_a : assert property (@(posedge clock) disable iff (rst)
    !register_bank_extend |-> working_bank == 2'b00) // [R20]
    else $error("working bank not forced to 0");
  narrow_ind_a : assert property (@(posedge clock) disable iff (rst)
    (!wide_ram_enable && req.mode == dba_pkg::DBA_IND_HL) |-> ea.addr[11:8] == 4'h0) // [R4]
    else $error("narrow indirect left bank 0");
  wide_bank_a : assert property (@(posedge clock) disable iff (rst)
    (wide_ram_enable && req.mode == dba_pkg::DBA_DIRECT) |-> ea.addr[11:8] == bank_select_pair[3:0]) // [R1] [R2]
    else $error("wide direct bank mismatch");
  narrow_dir_a : assert property (@(posedge clock) disable iff (rst)
    (!wide_ram_enable && req.mode == dba_pkg::DBA_DIRECT) |->
      ea.addr[11:8] == (req.operand[7] ? 4'hf : 4'h0)) // [R3]
    else $error("narrow direct bank wrong");
  short_bit_a : assert property (@(posedge clock) disable iff (rst)
    (req.mode == dba_pkg::DBA_BIT_SHORT) |-> (ea.addr[11:4] == 8'hfb || ea.addr[11:4] == 8'hff)) // [R11]
    else $error("short bit area outside bank 15 pages");
  lidx_bit_a : assert property (@(posedge clock) disable iff (rst)
    (req.mode == dba_pkg::DBA_BIT_LIDX) |-> (ea.addr[11:6] == 6'h3f && ea.bit_sel == req.index[1:0])) // [R12]
    else $error("low index bit address wrong");
  idx_page0_a : assert property (@(posedge clock) disable iff (rst)
    (req.mode == dba_pkg::DBA_IND_IDX) |-> ea.addr == {4'h0, req.index}) // [R10]
    else $error("index pair access left page 0");
  // Interrupt entry pushes whatever the live flags hold at that edge
  stack_view_a : assert property (@(posedge clock) disable iff (rst)
    irq_save |-> flags_to_stack == {wide_ram_enable, register_bank_extend}) // [R8]
    else $error("stacked flags differ from live flags");

endmodule : dba_bank_unit

// file: bench/dba_ram_model.sv
// Behavioural data RAM standing on the far side of the address former.
// Assumes the bench gives write and read enables in step with the clock.
module dba_ram_model (
  input wire logic clock,
  input wire logic we,
  input wire logic re,
  input wire dba_pkg::dba_addr_s ea,
  input wire logic [3:0] wdata,
  output logic [3:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mem [4096];
  logic [3:0] last_reg = 4'h0;

  // Store on the edge; remember the last read so an idle bus can show its inverse
  always_ff @(posedge clock) begin
    if (we) mem[ea.addr] <= wdata;
    if (re) last_reg <= mem[ea.addr];
  end

  // Not selected: inverted last value, so a stale read never looks right by luck
  assign rdata = re ? mem[ea.addr] : ~last_reg;
endmodule : dba_ram_model

// file: bench/data_memory_bank_addressing_bench.sv
// Self-checking bench for the bank unit with a RAM model behind it.
// Assumes the unit's hand-over timing: strobes taken at the rising edge.
module data_memory_bank_addressing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1, vec_load = 1'b0, irq_save = 1'b0, irq_restore = 1'b0;
  logic wide_bit_we = 1'b0, regx_bit_we = 1'b0, bit_value = 1'b0, wbs_load = 1'b0, mbs_load = 1'b0;
  logic pair_pop = 1'b0, ram_we = 1'b0, ram_re = 1'b0, m_wide, m_ext, wide_ram_enable, register_bank_extend;
  logic [7:0] vec_byte = 8'h00, pair_pop_data = 8'h00, bank_select_pair;
  logic [1:0] stacked_flags = 2'h0, wbs_value = 2'h0, flags_to_stack, working_bank, m_wbs;
  logic [3:0] mbs_value = 4'h0, ram_wd = 4'h0, ram_rd, m_mbs;
  dba_pkg::dba_req_s req = '0;
  dba_pkg::dba_addr_s ea;
  int err_count = 0, n_compared = 0;

  dba_bank_unit dut_u (.clock, .rst, .vec_load, .vec_byte, .irq_save, .irq_restore, .stacked_flags,
    .flags_to_stack, .wide_bit_we, .regx_bit_we, .bit_value, .wbs_load, .wbs_value, .mbs_load,
    .mbs_value, .pair_pop, .pair_pop_data, .bank_select_pair, .req, .ea, .wide_ram_enable,
    .register_bank_extend, .working_bank);
  dba_ram_model ram_u (.clock, .we(ram_we), .re(ram_re), .ea, .wdata(ram_wd), .rdata(ram_rd));

  // Free-running 25 ns clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  // ***************************************************************
  // Expectation and checking
  // ***************************************************************
  // Address expected for a request, from flag and memory bank select
  function automatic dba_pkg::dba_addr_s exp_ea(dba_pkg::dba_req_s r, logic w, logic [3:0] b);
    dba_pkg::dba_addr_s e;
    e.bit_sel = r.bit_in;
    case (r.mode)
      dba_pkg::DBA_DIRECT: e.addr = {w ? b : {4{r.operand[7]}}, r.operand};
      dba_pkg::DBA_IND_HL: e.addr = {w ? b : 4'h0, r.index};
      dba_pkg::DBA_IND_IDX: e.addr = {4'h0, r.index};
      dba_pkg::DBA_BIT_SHORT: e.addr = {4'hf, r.operand[6] ? 4'hf : 4'hb, r.operand[3:0]};
      dba_pkg::DBA_BIT_LIDX: begin
        e.addr = {6'h3f, r.operand[3:0], r.index[3:2]};
        e.bit_sel = r.index[1:0];
      end
      default: e.addr = {w ? b : 4'h0, r.index[7:4], r.operand[3:0]};
    endcase
    return e;
  endfunction : exp_ea

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Wait for an edge and advance the reference state from what the unit sampled
  task automatic tick();
    @(posedge clock);
    if (rst) {m_wide, m_ext, m_wbs, m_mbs} = 8'h00;
    else begin
      // Each flag ranks its own sources: vector, then bit write, then restore
      if (vec_load) {m_wide, m_ext} = vec_byte[7:6];
      else begin
        if (wide_bit_we) m_wide = bit_value;
        else if (irq_restore) m_wide = stacked_flags[1];
        if (regx_bit_we) m_ext = bit_value;
        else if (irq_restore) m_ext = stacked_flags[0];
      end
      if (pair_pop) {m_wbs, m_mbs} = pair_pop_data[5:0];
      else begin
        if (wbs_load) m_wbs = wbs_value;
        if (mbs_load) m_mbs = mbs_value;
      end
    end
  endtask : tick

  // Flag source fop and select source sop; 5 and 6 pair two flag sources, 9 raises nearly all
  task automatic drive(int fop, int sop, dba_pkg::dba_mode_e md, logic bv, logic [3:0] mv, logic [7:0] op,
                       logic [7:0] ix);
    vec_load <= (fop == 0 || fop == 9);
    wide_bit_we <= (fop == 1 || fop == 5 || fop == 9);
    regx_bit_we <= (fop == 2 || fop == 5 || fop == 6);
    irq_restore <= (fop == 3 || fop == 6 || fop == 9);
    pair_pop <= (sop == 0 || sop == 9);
    wbs_load <= (sop == 1 || sop == 3 || sop == 9);
    mbs_load <= (sop == 2 || sop == 3 || sop == 9);
    irq_save <= 1'($urandom);
    vec_byte <= 8'($urandom);
    stacked_flags <= 2'($urandom);
    bit_value <= bv;
    wbs_value <= 2'($urandom);
    mbs_value <= mv;
    pair_pop_data <= {2'b00, 6'($urandom)};
    req <= '{mode: md, operand: op, index: ix, bit_in: 2'($urandom)};
  endtask : drive

  // Compare once the edge's updates and the new request have settled
  task automatic check_all();
    #1;
    check("ea", ea, exp_ea(req, m_wide, m_mbs));
    check("flags", {wide_ram_enable, register_bank_extend}, {m_wide, m_ext});
    check("stack", flags_to_stack, {m_wide, m_ext});
    check("pair", bank_select_pair, {2'b00, m_wbs, m_mbs});
    check("wbank", working_bank, m_ext ? m_wbs : 2'b00);
  endtask : check_all

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  // Watchdog: the run needs about 320 cycles
  initial begin
    repeat (2000) @(posedge clock);
    err_count++;
    stop_test();
  end

  initial begin
    void'($urandom(32'ha6ae_8c94));
    repeat (5) tick();
    rst <= 1'b0;
    drive(4, 4, dba_pkg::DBA_DIRECT, 1'b0, 4'h0, 8'h12, 8'h00);
    check_all();
    // Narrow mode with bank 15 selected: write F90H, then low page stays bank 0
    tick(); drive(1, 2, dba_pkg::DBA_DIRECT, 1'b0, 4'hf, 8'h90, 8'h00); check_all();
    tick(); drive(4, 4, dba_pkg::DBA_DIRECT, 1'b0, 4'hf, 8'h90, 8'h00); ram_we <= 1'b1; ram_wd <= 4'ha; check_all();
    tick(); drive(1, 4, dba_pkg::DBA_DIRECT, 1'b1, 4'hf, 8'h20, 8'h00); ram_we <= 1'b0; check_all();
    // Wide mode with bank 15: indirect reaches the same cell
    tick(); drive(4, 4, dba_pkg::DBA_IND_HL, 1'b0, 4'hf, 8'h00, 8'h90); ram_re <= 1'b1; check_all();
    check("ram", ram_rd, 4'ha);
    tick(); drive(9, 9, dba_pkg::DBA_IND_IDX, 1'b1, 4'h3, 8'h00, 8'h90); ram_re <= 1'b0; check_all();
    tick(); drive(4, 4, dba_pkg::DBA_DIRECT, 1'b0, 4'h3, 8'hfe, 8'h00); check_all();
    // Random traffic of every source and mode
    repeat (300) begin
      tick();
      drive(int'($urandom_range(0, 7)), int'($urandom_range(0, 7)), dba_pkg::dba_mode_e'($urandom_range(0, 5)),
            1'($urandom), 4'($urandom), 8'($urandom), 8'($urandom));
      check_all();
    end
    // Second reset in mid-run clears the selects and flags
    tick(); rst <= 1'b1; drive(4, 4, dba_pkg::DBA_DIRECT, 1'b0, 4'h0, 8'h85, 8'h00);
    tick(); drive(4, 4, dba_pkg::DBA_BIT_HIDX, 1'b0, 4'h0, 8'h05, 8'h37); check_all();
    tick(); rst <= 1'b0; drive(4, 4, dba_pkg::DBA_BIT_LIDX, 1'b0, 4'h0, 8'h0c, 8'h0b); check_all();
    // First edges after the second release: boot vector load and a bank select load
    tick(); drive(0, 2, dba_pkg::DBA_DIRECT, 1'b0, 4'h7, 8'h34, 8'h00); check_all();
    tick(); drive(4, 4, dba_pkg::DBA_IND_HL, 1'b0, 4'h7, 8'h34, 8'h46); check_all();
    tick(); check_all();
    stop_test();
  end
endmodule : data_memory_bank_addressing_bench
